// >>> rtl/switch_status_defs.vh
`ifndef SWITCH_STATUS_DEFS_VH
`define SWITCH_STATUS_DEFS_VH

// Register offsets on the serial register port
`define ADDR_W                 6
`define OFS_ANALOG_UPPER       6'h07
`define OFS_MATRIX_LOW         6'h08
`define OFS_MATRIX_HIGH_COMMON 6'h09

// Register geometry
`define REG_W                  24
`define REG_RESET              24'h000000

// Analog threshold status upper fields
`define LVL_W                  2
`define LVL19_MSB              3
`define LVL19_LSB              2
`define LVL18_MSB              1
`define LVL18_LSB              0
`define LVL_BELOW_A            2'h0
`define LVL_A_TO_B             2'h1
`define LVL_B_TO_C             2'h2
`define LVL_AT_C               2'h3

// Matrix fields
`define COLS_PER_ROW           6
`define MAT_LOW_ROWS           4
`define MAT_HIGH_ROWS          2
`define MAT_HIGH_MSB           11
`define COMMON_MSB             23
`define COMMON_LSB             12
`define COMMON_INPUTS          12

// Converter value width
`define ADC_W                  10

`endif

// >>> rtl/level_classifier.v
`include "switch_status_defs.vh"

module level_classifier #(
  parameter VAL_W = `ADC_W
) (
  input  wire [VAL_W-1:0]     value,
  input  wire [VAL_W-1:0]     thr_a,
  input  wire [VAL_W-1:0]     thr_b,
  input  wire [VAL_W-1:0]     thr_c,
  input  wire                 adc_mode,
  output reg  [`LVL_W-1:0]    level
);

  // Lower bounds inclusive, upper bounds exclusive
  always @*
  begin
    if (!adc_mode)
      level = `LVL_BELOW_A;
    else if (value >= thr_c)
      level = `LVL_AT_C;
    else if (value >= thr_b)
      level = `LVL_B_TO_C;
    else if (value >= thr_a)
      level = `LVL_A_TO_B;
    else
      level = `LVL_BELOW_A;
  end

endmodule // level_classifier

// >>> rtl/switch_matrix_status_regs.v
// Operation
// R01 - Bits 3-2 of the analog upper status hold the input-nineteen level: 0 below A, 1 A..B, 2 B..C, 3 at or above C.
// R02 - Bits 1-0 hold the input-eighteen level with the same coding, lower bounds inclusive and upper exclusive.
// R03 - The low matrix status register sits at offset 8h, resets to zero and holds rows ten to thirteen.
// R04 - Each row there takes six bits for columns nine down to four, row thirteen at 23-18 and row ten at 5-0.
// R05 - A matrix bit is 1 when the row was above threshold while its column was grounded, else 0.
// R06 - The high matrix register at offset 9h resets to zero; bits 11-6 hold row fifteen and 5-0 row fourteen.
// R07 - Bits 23-12 of the high register give the common-threshold result of inputs eleven down to zero.
// R08 - All these fields are read-only; host writes never change them.
// R09 - A common-threshold bit is 1 when its input is at or above the common threshold, else 0.
// R10 - The level fields only carry meaning for inputs set to converter mode, and read 0 otherwise.
// R11 - All status is loaded together at the end of each pass so one read never mixes two passes.
`include "switch_status_defs.vh"

module switch_matrix_status_regs #(
  parameter VAL_W = `ADC_W
) (
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire                      pass_done,
  input  wire                      adc_mode_eighteen,
  input  wire                      adc_mode_nineteen,
  input  wire [VAL_W-1:0]          adc_value_eighteen,
  input  wire [VAL_W-1:0]          adc_value_nineteen,
  input  wire [VAL_W-1:0]          thr_a,
  input  wire [VAL_W-1:0]          thr_b,
  input  wire [VAL_W-1:0]          thr_c,
  input  wire [23:0]               matrix_low_in,
  input  wire [11:0]               matrix_high_in,
  input  wire [`COMMON_INPUTS-1:0] common_cmp_in,
  input  wire                      reg_rd_en,
  input  wire                      reg_wr_en,
  input  wire [`ADDR_W-1:0]        reg_addr,
  input  wire [`REG_W-1:0]         reg_wr_data,
  output reg  [`REG_W-1:0]         reg_rd_data,
  output reg                       reg_rd_valid,
  output reg                       reg_addr_err
);

  // Address decode shared by read and write paths
  function is_mapped;
    input [`ADDR_W-1:0] a;
    begin
      is_mapped = (a == `OFS_ANALOG_UPPER) ||
                  (a == `OFS_MATRIX_LOW) ||
                  (a == `OFS_MATRIX_HIGH_COMMON);
    end
  endfunction

  wire [VAL_W-1:0]        adc_value [0:1];
  wire                    adc_mode  [0:1];
  wire [`LVL_W-1:0]       level     [0:1];

  assign adc_value[0] = adc_value_eighteen;
  assign adc_value[1] = adc_value_nineteen;
  assign adc_mode[0]  = adc_mode_eighteen;
  assign adc_mode[1]  = adc_mode_nineteen;

  // Level coding per converter input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_level
      // R10 mode gated level
      level_classifier #(
        .VAL_W    (VAL_W)
      ) u_level (
        .value    (adc_value[gi]),
        .thr_a    (thr_a),
        .thr_b    (thr_b),
        .thr_c    (thr_c),
        .adc_mode (adc_mode[gi]),
        .level    (level[gi])
      );
    end
  endgenerate

  reg  [`LVL_W-1:0]          level_status_input_eighteen_r;
  reg  [`LVL_W-1:0]          level_status_input_nineteen_r;
  reg  [23:0]                matrix_low_r;
  reg  [11:0]                matrix_high_r;
  reg  [`COMMON_INPUTS-1:0]  common_cmp_r;

  // R11 snapshot at pass end
  // Only the pass strobe loads status, so results of a half-done pass never show
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_status_input_eighteen_r <= `LVL_BELOW_A;
      level_status_input_nineteen_r <= `LVL_BELOW_A;
      matrix_low_r                  <= 24'h000000;
      matrix_high_r                 <= 12'h000;
      common_cmp_r                  <= 12'h000;
    end
    else if (pass_done)
    begin
      // R01 input nineteen level
      level_status_input_nineteen_r <= level[1];
      // R02 input eighteen level
      level_status_input_eighteen_r <= level[0];
      // R05 grounded column result
      matrix_low_r                  <= matrix_low_in;
      matrix_high_r                 <= matrix_high_in;
      // R09 common threshold result
      common_cmp_r                  <= common_cmp_in;
    end
  end

  // Register images
  reg  [`REG_W-1:0] analog_threshold_status_upper;
  reg  [`REG_W-1:0] matrix_row_status_low;
  reg  [`REG_W-1:0] matrix_row_status_high_and_common;

  always @*
  begin
    analog_threshold_status_upper = `REG_RESET;
    // R01 bits 3-2
    analog_threshold_status_upper[`LVL19_MSB:`LVL19_LSB] = level_status_input_nineteen_r;
    // R02 bits 1-0
    analog_threshold_status_upper[`LVL18_MSB:`LVL18_LSB] = level_status_input_eighteen_r;
    // R03 R04 row-major layout
    // Row thirteen lands at 23-18, column nine at the top of each row
    matrix_row_status_low = matrix_low_r;
    // R06 rows fifteen and fourteen
    matrix_row_status_high_and_common = `REG_RESET;
    matrix_row_status_high_and_common[`MAT_HIGH_MSB:0] = matrix_high_r;
    // R07 common bits 23-12
    matrix_row_status_high_and_common[`COMMON_MSB:`COMMON_LSB] = common_cmp_r;
  end

  // Read port; writes are decoded only to flag unmapped addresses
  reg  [`REG_W-1:0] rd_mux;

  always @*
  begin
    rd_mux = `REG_RESET;
    case (reg_addr)
      `OFS_ANALOG_UPPER:       rd_mux = analog_threshold_status_upper;
      `OFS_MATRIX_LOW:         rd_mux = matrix_row_status_low;
      `OFS_MATRIX_HIGH_COMMON: rd_mux = matrix_row_status_high_and_common;
      default:                 rd_mux = `REG_RESET;
    endcase
  end

  // R08 writes never reach status
  // reg_wr_data is deliberately not stored anywhere
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rd_data  <= `REG_RESET;
      reg_rd_valid <= 1'b0;
      reg_addr_err <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      reg_addr_err <= (reg_rd_en | reg_wr_en) & ~is_mapped(reg_addr);
      if (reg_rd_en)
        reg_rd_data <= rd_mux;
    end
  end

endmodule // switch_matrix_status_regs

// >>> dv/host_model.sv
module host_model (
  input  wire         clk,
  output logic        rd_en = 1'b0,
  output logic        wr_en = 1'b0,
  output logic [5:0]  addr  = 6'h00,
  output logic [23:0] wd    = 24'h000000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Junk write data, so an accepted write would show up in later reads
  task automatic acc(input logic w, input logic [5:0] a);
    @(negedge clk);
    {rd_en, wr_en, addr, wd} = {~w, w, a, 24'hFFFFFF};
    @(negedge clk);
    {rd_en, wr_en} = 2'h0;
  endtask
endmodule // host_model

// >>> dv/status_regs_chk.sv
module status_regs_chk (
  input logic        clk,
  input logic        rst_n,
  input logic        pass_done,
  input logic [23:0] matrix_low_in,
  input logic [11:0] matrix_high_in,
  input logic [11:0] common_cmp_in,
  input logic        reg_rd_en,
  input logic        reg_wr_en,
  input logic [5:0]  reg_addr,
  input logic [23:0] reg_rd_data,
  input logic        reg_rd_valid,
  input logic        reg_addr_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire hit = reg_addr >= 6'h07 && reg_addr <= 6'h09;
  wire bad = (reg_rd_en || reg_wr_en) && !hit;
  property p_valid; reg_rd_en |=> reg_rd_valid; endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_quiet; !reg_rd_en |=> !reg_rd_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("valid without read");
  property p_err; bad |=> reg_addr_err; endproperty
  a_err: assert property (p_err) else $error("unmapped access unflagged");
  property p_noerr; !bad |=> !reg_addr_err; endproperty
  a_noerr: assert property (p_noerr) else $error("spurious error");
  property p_hold; !reg_rd_en |=> $stable(reg_rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_low; pass_done ##1 (reg_rd_en && reg_addr == 6'h08) |=> reg_rd_data == $past(matrix_low_in, 2); endproperty
  a_low: assert property (p_low) else $error("low matrix mismatch");
  property p_high; pass_done ##1 (reg_rd_en && reg_addr == 6'h09)
    |=> reg_rd_data == {$past(common_cmp_in, 2), $past(matrix_high_in, 2)}; endproperty
  a_high: assert property (p_high) else $error("high matrix mismatch");
  property p_upper; reg_rd_en && reg_addr == 6'h07 |=> reg_rd_data[23:4] == 20'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
endmodule // status_regs_chk

// >>> dv/switch_matrix_status_regs_test.sv
module switch_matrix_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, pass_done = 0, mode18 = 1, mode19 = 1;
  logic [9:0]  v18 = 10'h000, v19 = 10'h000;
  logic [23:0] mlow = 24'h000000;
  logic [11:0] mhigh = 12'h000, com = 12'h000;
  wire         rd_en, wr_en, rd_valid, addr_err;
  wire  [5:0]  addr;
  wire  [23:0] wd, rd_data;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  host_model i_host_model (.clk(clk), .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wd(wd));
  switch_matrix_status_regs i_switch_matrix_status_regs (.clk(clk), .rst_n(rst_n), .pass_done(pass_done),
    .adc_mode_eighteen(mode18), .adc_mode_nineteen(mode19), .adc_value_eighteen(v18), .adc_value_nineteen(v19),
    .thr_a(10'h064), .thr_b(10'h0C8), .thr_c(10'h12C), .matrix_low_in(mlow), .matrix_high_in(mhigh),
    .common_cmp_in(com), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wd),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .reg_addr_err(addr_err));
  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [25:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e, input logic err = 0);
    // Valid stands for one cycle only, so judge at the falling edge that ends the strobe
    i_host_model.acc(0, a);
    chk({rd_valid, addr_err, rd_data}, {1'b1, err, e});
  endtask
  task automatic ld(input logic [23:0] l, input logic [11:0] h, c, input logic [19:0] an);
    @(negedge clk);
    {mlow, mhigh, com, v19, v18, pass_done} = {l, h, c, an, 1'b1};
    @(negedge clk);
    pass_done = 0;
  endtask
  task automatic t_reset;
    rd(6'h08, 24'h0);
    rd(6'h09, 24'h0);
    ld(24'hC3C3C3, 12'h96F, 12'h1E1, {10'h12C, 10'h0C8});
    rd(6'h07, 24'h00000E);
    rd(6'h08, 24'hC3C3C3);
    @(negedge clk);
    rst_n = 0;
    repeat (3) @(negedge clk);
    chk({rd_valid, addr_err, rd_data}, 26'h0000000);
    rst_n = 1;
    rd(6'h07, 24'h0);
    rd(6'h08, 24'h0);
    rd(6'h09, 24'h0);
  endtask
  task automatic t_matrix;
    logic [11:0] h, c;
    for (int i = 0; i < 24; i++)
    begin
      h = 12'h001 << (i % 12);
      c = 12'h800 >> (i % 12);
      ld(24'h000001 << i, h, c, 20'h0);
      rd(6'h08, 24'h000001 << i);
      rd(6'h09, {c, h});
    end
  endtask
  task automatic t_level;
    logic [9:0] v [6] = '{10'h063, 10'h064, 10'h0C7, 10'h0C8, 10'h12B, 10'h12C};
    logic [1:0] e [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    for (int i = 0; i < 6; i++)
    begin
      ld(mlow, mhigh, com, {v[i], v[5-i]});
      rd(6'h07, {20'h0, e[i], e[5-i]});
    end
    @(negedge clk);
    mode19 = 0;
    ld(mlow, mhigh, com, {10'h12C, 10'h12C});
    rd(6'h07, 24'h000003);
  endtask
  task automatic t_write;
    ld(24'h5A5A5A, 12'hA5A, 12'h3C3, 20'h0);
    for (int a = 7; a < 10; a++)
      i_host_model.acc(1, a[5:0]);
    rd(6'h09, 24'h3C3A5A);
    rd(6'h08, 24'h5A5A5A);
    rd(6'h31, 24'h0, 1);
    rd(6'h07, 24'h0);
    i_host_model.acc(1, 6'h3F);
    chk({24'h000000, rd_valid, addr_err}, 26'h0000001);
  endtask
  task automatic t_atomic;
    fork
      ld(24'hFFFFFF, 12'hFFF, 12'hFFF, 20'h0);
      rd(6'h08, 24'h5A5A5A);
    join
    rd(6'h09, 24'hFFFFFF);
    // A read one cycle after the pass strobe must already see the new pass
    fork
      ld(24'h123456, 12'h789, 12'hABC, 20'h0);
      begin
        @(negedge clk);
        rd(6'h08, 24'h123456);
      end
    join
    fork
      ld(24'h654321, 12'h5C3, 12'h2E1, 20'h0);
      begin
        @(negedge clk);
        rd(6'h09, 24'h2E15C3);
      end
    join
  endtask
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    t_reset;
    t_matrix;
    t_level;
    t_write;
    t_atomic;
    finish_test;
  end
endmodule // switch_matrix_status_regs_test
bind switch_matrix_status_regs status_regs_chk i_chk (.clk, .rst_n, .pass_done, .matrix_low_in, .matrix_high_in,
  .common_cmp_in, .reg_rd_en, .reg_wr_en, .reg_addr, .reg_rd_data, .reg_rd_valid, .reg_addr_err);
